// >>> core/voltage_sense_gain_trim.sv
// Gain-trim stage for three voltage-sense ADC channels with AXI4-Lite registers.
// Assumes ADC samples arrive on aclk with a valid strobe; no clock crossing needed.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module voltage_sense_gain_trim (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire gain_trim_pkg::sample_t    sense_channel_one,
    input  wire gain_trim_pkg::sample_t    sense_channel_two,
    input  wire gain_trim_pkg::sample_t    sense_channel_three,
    input  wire logic [9:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [9:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [11:0]                    trimmed_one,
    output logic [11:0]                    trimmed_two,
    output logic [11:0]                    trimmed_three
);

    // Gain is 1 +/- magnitude/1024; result saturates to the 12-bit range.
    function automatic logic [11:0] apply_trim(input logic [11:0] raw,
                                               input gain_trim_pkg::trim_t t);
        logic [19:0] delta;
        logic [13:0] sum;
        delta = 20'(raw) * 20'(t.magnitude);
        sum   = 14'(raw);
        if (t.magnitude == 7'h00) begin
            sum = 14'(raw);
        end else if (t.polarity) begin
            sum = 14'(raw) - 14'(delta >> gain_trim_pkg::trim_shift);
        end else begin
            sum = 14'(raw) + 14'(delta >> gain_trim_pkg::trim_shift);
        end
        if (sum[13]) begin
            apply_trim = 12'h000;
        end else if (sum[12]) begin
            apply_trim = 12'hfff;
        end else begin
            apply_trim = sum[11:0];
        end
    endfunction : apply_trim

    function automatic logic [7:0] word_index(input logic [9:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    gain_trim_pkg::trim_t trim_one_ff, trim_two_ff, trim_three_ff;
    gain_trim_pkg::trim_t nxt_trim_one, nxt_trim_two, nxt_trim_three;
    logic [11:0]  nxt_trimmed_one, nxt_trimmed_two, nxt_trimmed_three;

    logic         aw_held_ff, w_held_ff, nxt_aw_held, nxt_w_held;
    logic [9:0]   aw_addr_ff, nxt_aw_addr;
    logic [31:0]  w_data_ff, nxt_w_data;
    logic         w_strb0_ff, nxt_w_strb0;
    logic         nxt_bvalid, nxt_rvalid;
    logic [1:0]   nxt_bresp, nxt_rresp;
    logic [31:0]  nxt_rdata;
    logic         nxt_awready, nxt_wready, nxt_arready;

    // Trimmed values: each channel updates on its own sample strobe
    always_comb begin
        nxt_trimmed_one   = trimmed_one;
        nxt_trimmed_two   = trimmed_two;
        nxt_trimmed_three = trimmed_three;
        if (sense_channel_one.valid) begin
            nxt_trimmed_one = apply_trim(sense_channel_one.reading, trim_one_ff);
        end
        if (sense_channel_two.valid) begin
            nxt_trimmed_two = apply_trim(sense_channel_two.reading, trim_two_ff);
        end
        if (sense_channel_three.valid) begin
            nxt_trimmed_three = apply_trim(sense_channel_three.reading, trim_three_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trimmed_one   <= 12'h000;
            trimmed_two   <= 12'h000;
            trimmed_three <= 12'h000;
        end else begin
            trimmed_one   <= nxt_trimmed_one;
            trimmed_two   <= nxt_trimmed_two;
            trimmed_three <= nxt_trimmed_three;
        end
    end

    // Write path: address and data captured in either order, answered once both held
    always_comb begin
        logic         aw_take;
        logic         w_take;
        logic         do_write;
        logic         mapped;
        aw_take        = s_axi_awvalid && s_axi_awready;
        w_take         = s_axi_wvalid && s_axi_wready;
        mapped         = 1'b0;
        do_write       = aw_held_ff && w_held_ff && !s_axi_bvalid;
        nxt_aw_held    = aw_held_ff || aw_take;
        nxt_w_held     = w_held_ff || w_take;
        nxt_aw_addr    = aw_take ? s_axi_awaddr : aw_addr_ff;
        nxt_w_data     = w_take ? s_axi_wdata : w_data_ff;
        nxt_w_strb0    = w_take ? s_axi_wstrb[0] : w_strb0_ff;
        nxt_trim_one   = trim_one_ff;
        nxt_trim_two   = trim_two_ff;
        nxt_trim_three = trim_three_ff;
        nxt_bvalid     = s_axi_bvalid && !s_axi_bready;
        nxt_bresp      = s_axi_bresp;
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            case (word_index(aw_addr_ff))
                gain_trim_pkg::idx_trim_one: begin
                    mapped = 1'b1;
                    if (w_strb0_ff) nxt_trim_one = w_data_ff[7:0];
                end
                gain_trim_pkg::idx_trim_two: begin
                    mapped = 1'b1;
                    if (w_strb0_ff) nxt_trim_two = w_data_ff[7:0];
                end
                gain_trim_pkg::idx_trim_three: begin
                    mapped = 1'b1;
                    if (w_strb0_ff) nxt_trim_three = w_data_ff[7:0];
                end
                gain_trim_pkg::idx_value_one,
                gain_trim_pkg::idx_value_two,
                gain_trim_pkg::idx_value_three: begin
                    mapped = 1'b1; // Read-only values: write ignored, OKAY
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
            nxt_bresp = mapped ? gain_trim_pkg::resp_okay : gain_trim_pkg::resp_slverr;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready  = !nxt_w_held && !nxt_bvalid;
    end

    // Read path: one read at a time, answer registered one cycle after acceptance
    always_comb begin
        nxt_rvalid  = s_axi_rvalid && !s_axi_rready;
        nxt_rdata   = s_axi_rdata;
        nxt_rresp   = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = gain_trim_pkg::resp_okay;
            case (word_index(s_axi_araddr))
                gain_trim_pkg::idx_value_one:   nxt_rdata = {20'h00000, trimmed_one};
                gain_trim_pkg::idx_value_two:   nxt_rdata = {20'h00000, trimmed_two};
                gain_trim_pkg::idx_value_three: nxt_rdata = {20'h00000, trimmed_three};
                gain_trim_pkg::idx_trim_one:    nxt_rdata = {24'h000000, trim_one_ff};
                gain_trim_pkg::idx_trim_two:    nxt_rdata = {24'h000000, trim_two_ff};
                gain_trim_pkg::idx_trim_three:  nxt_rdata = {24'h000000, trim_three_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = gain_trim_pkg::resp_slverr;
                end
            endcase
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_one_ff   <= gain_trim_pkg::trim_reset;
            trim_two_ff   <= gain_trim_pkg::trim_reset;
            trim_three_ff <= gain_trim_pkg::trim_reset;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            aw_addr_ff    <= 10'h000;
            w_data_ff     <= 32'h00000000;
            w_strb0_ff    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            trim_one_ff   <= nxt_trim_one;
            trim_two_ff   <= nxt_trim_two;
            trim_three_ff <= nxt_trim_three;
            aw_held_ff    <= nxt_aw_held;
            w_held_ff     <= nxt_w_held;
            aw_addr_ff    <= nxt_aw_addr;
            w_data_ff     <= nxt_w_data;
            w_strb0_ff    <= nxt_w_strb0;
            s_axi_awready <= nxt_awready;
            s_axi_wready  <= nxt_wready;
            s_axi_bvalid  <= nxt_bvalid;
            s_axi_bresp   <= nxt_bresp;
            s_axi_arready <= nxt_arready;
            s_axi_rvalid  <= nxt_rvalid;
            s_axi_rdata   <= nxt_rdata;
            s_axi_rresp   <= nxt_rresp;
        end
    end

endmodule : voltage_sense_gain_trim

`default_nettype wire

// >>> pkg/gain_trim_pkg.sv
// Package for the three-channel voltage-sense gain-trim block.
// Assumes an AXI4-Lite register slave with 32-bit data, one word per register.
package gain_trim_pkg;

    // Printed offsets are not all multiples of four: they are indexes, byte address = 4 * index
    localparam logic [7:0]  idx_value_one      = 8'h15;
    localparam logic [7:0]  idx_value_two      = 8'h16;
    localparam logic [7:0]  idx_value_three    = 8'h17;
    localparam logic [7:0]  idx_trim_one       = 8'h38;
    localparam logic [7:0]  idx_trim_two       = 8'h39;
    localparam logic [7:0]  idx_trim_three     = 8'h3a;

    localparam int          adc_width          = 12;
    localparam int          num_channels       = 3;
    localparam int          polarity_bit       = 7;
    localparam int          trim_shift         = 10;
    localparam logic [7:0]  trim_reset         = 8'h00;
    localparam logic [1:0]  resp_okay          = 2'h0;
    localparam logic [1:0]  resp_slverr        = 2'h2;

    typedef struct packed {
        logic        polarity;
        logic [6:0]  magnitude;
    } trim_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] reading;
    } sample_t;

endpackage : gain_trim_pkg

// >>> verification/gain_trim_chk.sv
// Checker for the gain-trim block: bus handshakes and trimmed outputs.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gain_trim_chk (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire gain_trim_pkg::sample_t sense_channel_one,
    input wire gain_trim_pkg::sample_t sense_channel_two,
    input wire gain_trim_pkg::sample_t sense_channel_three,
    input wire logic [11:0]            trimmed_one,
    input wire logic [11:0]            trimmed_two,
    input wire logic [11:0]            trimmed_three,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [9:0]             s_axi_araddr,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    hold_one_a: assert property (!sense_channel_one.valid |=> $stable(trimmed_one))
        else $error("channel one output moved without a sample");
    hold_two_a: assert property (!sense_channel_two.valid |=> $stable(trimmed_two))
        else $error("channel two output moved without a sample");
    hold_three_a: assert property (!sense_channel_three.valid |=> $stable(trimmed_three))
        else $error("channel three output moved without a sample");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not answered one cycle after address");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    hole_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h000
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (sense_channel_three.valid);
endmodule : gain_trim_chk
bind voltage_sense_gain_trim gain_trim_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .sense_channel_one(sense_channel_one), .sense_channel_two(sense_channel_two),
    .sense_channel_three(sense_channel_three), .trimmed_one(trimmed_one),
    .trimmed_two(trimmed_two), .trimmed_three(trimmed_three), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));
`default_nettype wire

// >>> verification/tb.sv
// Testbench for the gain-trim block: trim registers, sample path, value reads.
// Assumes one 10 MHz clock; response readies stay high, so answers are taken at once.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] trimmed_one, trimmed_two, trimmed_three;
    gain_trim_pkg::sample_t sense_channel_one, sense_channel_two, sense_channel_three;
    int bad_count, checked;
    voltage_sense_gain_trim u_voltage_sense_gain_trim (.aclk(aclk), .aresetn(aresetn),
        .sense_channel_one(sense_channel_one), .sense_channel_two(sense_channel_two),
        .sense_channel_three(sense_channel_three), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'h1),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'h1), .trimmed_one(trimmed_one),
        .trimmed_two(trimmed_two), .trimmed_three(trimmed_three));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Handshake seen at the falling edge is the one sampled at the next rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n = 0;
        logic done = 1'h0;
        logic [2:0] tk;
        @(posedge aclk);
        if (wr) begin
            s_axi_awaddr <= {idx, 2'h0};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
        end else begin
            s_axi_araddr <= {idx, 2'h0};
            s_axi_arvalid <= 1'h1;
        end
        while (!done && n < 40) begin
            @(negedge aclk);
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
            tk = {s_axi_awready, s_axi_wready, s_axi_arready};
            @(posedge aclk);
            if (tk[2]) s_axi_awvalid <= 1'h0;
            if (tk[1]) s_axi_wvalid <= 1'h0;
            if (tk[0]) s_axi_arvalid <= 1'h0;
            n++;
        end
        if (!done) begin
            bad_count++;
            final_report();
        end
    endtask : bus
    task automatic samp(input int ch, input logic [11:0] v);
        @(posedge aclk);
        case (ch)
            0: sense_channel_one <= {1'h1, v};
            1: sense_channel_two <= {1'h1, v};
            default: sense_channel_three <= {1'h1, v};
        endcase
        @(posedge aclk);
        sense_channel_one.valid <= 1'h0;
        sense_channel_two.valid <= 1'h0;
        sense_channel_three.valid <= 1'h0;
        @(negedge aclk);
    endtask : samp
    function automatic logic [11:0] gain(input logic [11:0] v, input logic [7:0] t);
        logic [18:0] dl;
        dl = ({7'h0, v} * {12'h0, t[6:0]}) >> 10;
        if (t[7]) return v - dl[11:0];
        return ({7'h0, v} + dl > 19'hfff) ? 12'hfff : v + dl[11:0];
    endfunction : gain
    // Calibration point, negative trim, zero magnitude with negative sign, saturation
    task automatic gain_cases();
        logic [11:0] rd [4] = '{12'ha28, 12'ha28, 12'h7d0, 12'hfa0};
        logic [7:0] tr [4] = '{8'h11, 8'h91, 8'h80, 8'h7f};
        logic [31:0] q;
        logic [1:0] r;
        logic [11:0] o;
        for (int c = 0; c < 3; c++) begin
            bus(0, 8'h38 + 8'(c), 32'h0, q, r);
            chk(q, {24'h0, gain_trim_pkg::trim_reset});
            for (int k = 0; k < 4; k++) begin
                bus(1, 8'h38 + 8'(c), {24'h0, tr[k]}, q, r);
                bus(0, 8'h38 + 8'(c), 32'h0, q, r);
                chk(q, {24'h0, tr[k]});
                samp(c, rd[k]);
                o = (c == 0) ? trimmed_one : (c == 1) ? trimmed_two : trimmed_three;
                chk({20'h0, o}, {20'h0, gain(rd[k], tr[k])});
                bus(0, 8'h15 + 8'(c), 32'h0, q, r);
                chk(q, {20'h0, gain(rd[k], tr[k])});
                if (k == 0) chk(q, 32'h00000a53);
            end
        end
    endtask : gain_cases
    task automatic odd_access();
        logic [31:0] q;
        logic [1:0] r;
        bus(0, 8'h00, 32'h0, q, r);
        chk({30'h0, r}, {30'h0, gain_trim_pkg::resp_slverr});
        chk(q, 32'h0);
        bus(1, 8'h15, 32'h0, q, r);
        chk({30'h0, r}, {30'h0, gain_trim_pkg::resp_okay});
        bus(0, 8'h15, 32'h0, q, r);
        chk(q, {20'h0, gain(12'hfa0, 8'h7f)});
        // Trim write without its low byte strobe must leave the trim alone
        s_axi_wstrb <= 4'h0;
        bus(1, 8'h38, 32'h00000055, q, r);
        s_axi_wstrb <= 4'hf;
        chk({30'h0, r}, {30'h0, gain_trim_pkg::resp_okay});
        bus(0, 8'h38, 32'h0, q, r);
        chk(q, 32'h0000007f);
    endtask : odd_access
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        s_axi_wstrb = 4'hf;
        {sense_channel_one, sense_channel_two, sense_channel_three} = 39'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        gain_cases();
        odd_access();
        final_report();
    end
endmodule : tb
`default_nettype wire
